// >>> inc/sar_readout_defines.vh
`ifndef SAR_READOUT_DEFINES_VH
`define SAR_READOUT_DEFINES_VH

// clock and conversion timing; cycle counts sized to match the 16-bit timer
`define CLK_PERIOD_NS 5
`define CONV_TIME_NS 200
`define CONV_CYCLES 16'h0028
// pin sync, edge detect and push stages are spent out of the conversion budget
`define CONV_SLACK_CYCLES 16'h0005

// powerdown entry and exit delay, 1000 ns each in 5 ns cycles
`define PD_ENTRY_TIME_NS 1000
`define PD_ENTRY_CYCLES 16'h00C8
`define PD_EXIT_DELAY_NS 1000
`define PD_EXIT_CYCLES 16'h00C8
// pin sync and state stages are spent out of the exit delay
`define PD_EXIT_SLACK_CYCLES 16'h0004

// abort must land within this time of reset entry
`define ABORT_LIMIT_NS 45

// result layout and codes
`define RESULT_WIDTH 12
`define LOW_NIBBLE_MSB 3
`define BYTE_ZERO_FILL 8'h00
`define RESET_MARK_CODE 12'hFE0
`define RESULT_RESET_VALUE 12'h000
`define INIT_CONVERSIONS 3'h4

// result buffer
`define FIFO_DEPTH 8
`define FIFO_PTR_WIDTH 3

// control states
`define ST_IDLE 3'h0
`define ST_CONVERT 3'h1
`define ST_PUSH 3'h2
`define ST_RESET 3'h3
`define ST_POWERDOWN 3'h4
`define ST_WAKE 3'h5

`endif

// >>> verification/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
(
  input wire logic clock,
  input wire logic [11:0] pinsOut,
  input wire logic oeN,
  output logic [11:0] busLevel
);
  logic [11:0] lastDriven = 12'h000;
  // remember the last driven word
  always @(posedge clock)
  begin
    if (!oeN)
      lastDriven <= pinsOut;
  end
  // released bus shows the inverse, so a stale word never passes
  assign busLevel = oeN ? ~lastDriven : pinsOut;
endmodule // host_bus_model
`default_nettype wire

// >>> verification/sar_readout_properties.sv
`timescale 1ns/100ps
`default_nettype none
module sar_readout_properties
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic convert_start_n,
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic byteSelect,
  input wire logic powerdown_reset_n,
  input wire logic busy,
  input wire logic [11:0] parallel_data_pins_out,
  input wire logic parallel_data_pins_oe_n,
  input wire logic resultInvalid,
  input wire logic poweredDown,
  input wire logic bufferFull
);
  logic [8:0] lowCount;
  logic [8:0] highCount;
  logic [6:0] busyCount;
  wire logic readReq = !chipSelect_n && !readStrobe_n;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // run lengths, saturating so long idles never wrap
  always @(posedge clock)
  begin
    lowCount <= (sys_rst || powerdown_reset_n) ? 9'h000 : lowCount + {8'h00, lowCount != 9'h1FF};
    highCount <= (sys_rst || !powerdown_reset_n) ? 9'h000 : highCount + {8'h00, highCount != 9'h1FF};
    busyCount <= (sys_rst || !busy) ? 7'h00 : busyCount + {6'h00, busyCount != 7'h7F};
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_bus_needs_select: assert property (!parallel_data_pins_oe_n |-> $past(readReq, 3))
    else $error("pins driven without select and strobe");
  a_byte_high_zeros: assert property (!parallel_data_pins_oe_n && $past(byteSelect, 3)
    && $past(byteSelect, 4) |-> parallel_data_pins_out[7:0] == 8'h00)
    else $error("byte mode lower lines not zero");
  // busy past 37 cycles only when back-pressure holds the push
  a_busy_bound: assert property (busy && busyCount == 7'h25 |-> bufferFull || $past(bufferFull))
    else $error("conversion too long");
  a_start_sets_busy: assert property ($fell(convert_start_n) && !chipSelect_n && !busy
    && !poweredDown && highCount > 9'h004 |-> ##[2:4] busy)
    else $error("start edge did not raise busy");
  a_reset_aborts: assert property ($fell(powerdown_reset_n) && busy |-> ##[1:9] !busy)
    else $error("conversion not aborted by reset pin");
  a_reset_code: assert property (lowCount > 9'h005 && !poweredDown && !parallel_data_pins_oe_n
    && $past(!byteSelect, 3) && $past(!byteSelect, 4) |-> parallel_data_pins_out == 12'hFE0)
    else $error("reset marker missing");
  a_powerdown_entry: assert property (lowCount == 9'hD2 |-> poweredDown)
    else $error("powerdown not entered");
  a_wake_delay: assert property ($fell(poweredDown) |-> highCount inside {[9'hC4:9'hC9]})
    else $error("wake delay out of range");
  a_reset_invalid: assert property ($fell(powerdown_reset_n) |-> ##[2:5] resultInvalid)
    else $error("results not flagged invalid");
  c_abort: cover property ($fell(busy) && !chipSelect_n && convert_start_n);
  c_full: cover property (busy && bufferFull);
  c_wake: cover property ($fell(poweredDown));
endmodule // sar_readout_properties
bind sar_readout_ctrl sar_readout_properties props (.clock, .sys_rst, .convert_start_n,
  .chipSelect_n, .readStrobe_n, .byteSelect, .powerdown_reset_n, .busy, .parallel_data_pins_out,
  .parallel_data_pins_oe_n, .resultInvalid, .poweredDown, .bufferFull);
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic convert_start_n = 1'b1;
  logic chipSelect_n = 1'b1;
  logic readStrobe_n = 1'b1;
  logic byteSelect = 1'b0;
  logic powerdown_reset_n = 1'b1;
  logic [11:0] analogWord = 12'h000;
  wire logic busy, parallel_data_pins_oe_n, resultInvalid, poweredDown, bufferFull;
  wire logic [11:0] parallel_data_pins_out, busLevel;
  int failures = 0;
  int tests_run = 0;
  sar_readout_ctrl dut (.clock, .sys_rst, .convert_start_n, .chipSelect_n, .readStrobe_n,
    .byteSelect, .powerdown_reset_n, .analogWord, .busy, .parallel_data_pins_out,
    .parallel_data_pins_oe_n, .resultInvalid, .poweredDown, .bufferFull);
  host_bus_model host (.clock, .pinsOut(parallel_data_pins_out), .oeN(parallel_data_pins_oe_n),
    .busLevel);
  // 200 MHz clock
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] want);
    tests_run++;
    if (seen !== want)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // start pin falls with select low; bus stays quiet around the edge
  task automatic convert(input logic [11:0] w);
    int k;
    analogWord = w;
    chipSelect_n = 1'b0;
    cyc(3);
    convert_start_n = 1'b0;
    cyc(6);
    check("busy", {11'h000, busy}, 12'h001);
    convert_start_n = 1'b1;
    chipSelect_n = 1'b1;
    for (k = 0; k < 400 && busy !== 1'b0; k++)
      cyc(1);
    check("conv_time", {11'h000, k <= 34}, 12'h001);
    cyc(4);
  endtask
  task automatic read_word(input logic b, input logic [11:0] want);
    byteSelect = b;
    chipSelect_n = 1'b0;
    readStrobe_n = 1'b0;
    cyc(5);
    check("bus", busLevel, want);
  endtask
  task automatic release_bus;
    chipSelect_n = 1'b1;
    readStrobe_n = 1'b1;
    cyc(5);
    check("oe_n", {11'h000, parallel_data_pins_oe_n}, 12'h001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    read_word(1'b0, 12'hFE0);
    release_bus;
    for (int i = 0; i < 4; i++)
    begin
      check("invalid", {11'h000, resultInvalid}, 12'h001);
      convert(12'h5A5);
    end
    check("invalid", {11'h000, resultInvalid}, 12'h000);
  endtask
  // both byte halves, strobe toggled and strobe held
  task automatic t_codes;
    logic [11:0] codes [4] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000};
    foreach (codes[i])
    begin
      convert(codes[i]);
      read_word(1'b0, codes[i]);
      release_bus;
      read_word(1'b1, {codes[i][3:0], 8'h00});
      byteSelect = 1'b0;
      cyc(5);
      check("held", busLevel, codes[i]);
      release_bus;
    end
  endtask
  task automatic t_abort;
    chipSelect_n = 1'b0;
    cyc(3);
    convert_start_n = 1'b0;
    cyc(3);
    convert_start_n = 1'b1;
    chipSelect_n = 1'b1;
    cyc(4);
    chipSelect_n = 1'b0;
    cyc(6);
    check("busy", {11'h000, busy}, 12'h000);
    chipSelect_n = 1'b1;
    cyc(4);
    read_word(1'b0, 12'hFE0);
    release_bus;
  endtask
  task automatic t_pin_reset;
    chipSelect_n = 1'b0;
    cyc(3);
    convert_start_n = 1'b0;
    cyc(5);
    powerdown_reset_n = 1'b0;
    cyc(12);
    check("busy", {11'h000, busy}, 12'h000);
    convert_start_n = 1'b1;
    chipSelect_n = 1'b1;
    cyc(3);
    read_word(1'b0, 12'hFE0);
    release_bus;
    powerdown_reset_n = 1'b1;
    cyc(5);
    check("down", {11'h000, poweredDown}, 12'h000);
    convert(12'h123);
    check("invalid", {11'h000, resultInvalid}, 12'h001);
  endtask
  task automatic t_powerdown;
    int k;
    powerdown_reset_n = 1'b0;
    cyc(150);
    check("down", {11'h000, poweredDown}, 12'h000);
    cyc(80);
    check("down", {11'h000, poweredDown}, 12'h001);
    powerdown_reset_n = 1'b1;
    for (k = 0; k < 260 && poweredDown !== 1'b0; k++)
      cyc(1);
    check("wake", {11'h000, k < 202}, 12'h001);
    for (int i = 0; i < 4; i++)
      convert(12'h3C3);
    check("invalid", {11'h000, resultInvalid}, 12'h000);
  endtask
  // a held read blocks draining, so nine results overfill the buffer
  task automatic t_fill;
    chipSelect_n = 1'b0;
    readStrobe_n = 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      analogWord = 12'h100 + i[11:0];
      convert_start_n = 1'b0;
      cyc(4);
      convert_start_n = 1'b1;
      cyc(50);
    end
    check("full", {10'h000, bufferFull, busy}, 12'h003);
    check("held", busLevel, 12'h3C3);
    readStrobe_n = 1'b1;
    cyc(60);
    read_word(1'b0, 12'h108);
    release_bus;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(5);
    sys_rst = 1'b0;
    cyc(6);
    // host pulses the reset pin once supply is up
    powerdown_reset_n = 1'b0;
    cyc(10);
    powerdown_reset_n = 1'b1;
    cyc(6);
    t_init;
    t_codes;
    t_abort;
    t_pin_reset;
    t_powerdown;
    t_fill;
    report_and_stop;
  end
  // hang guard, well beyond the expected run
  initial
  begin
    #50000;
    failures++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire

// >>> verilog/result_fifo.v
`timescale 1ns/100ps
`default_nettype none

module result_fifo
#(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter PTR_WIDTH = 3
)
(
  input wire clock,
  input wire sys_rst,
  input wire flush,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_WIDTH-1:0] writePtr;
  reg [PTR_WIDTH-1:0] readPtr;
  reg [PTR_WIDTH:0] count;
  wire doWrite;
  wire doRead;

  ////////////////////////////////////////////////////////////////////////////
  // honest flags; a full buffer stalls the writer
  assign inReady = (count != DEPTH[PTR_WIDTH:0]);
  assign outValid = (count != {(PTR_WIDTH+1){1'b0}});
  assign outData = store[readPtr];
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;

  // pointers wrap naturally since depth is a power of two
  always @(posedge clock)
  begin
    if (sys_rst || flush)
    begin
      writePtr <= {PTR_WIDTH{1'b0}};
      readPtr <= {PTR_WIDTH{1'b0}};
      count <= {(PTR_WIDTH+1){1'b0}};
    end
    else
    begin
      if (doWrite)
        writePtr <= writePtr + 1'b1;
      if (doRead)
        readPtr <= readPtr + 1'b1;
      if (doWrite && !doRead)
        count <= count + 1'b1;
      else if (doRead && !doWrite)
        count <= count - 1'b1;
    end
  end

  // storage has no reset; only written slots are ever read
  always @(posedge clock)
  begin
    if (doWrite)
      store[writePtr] <= inData;
  end

endmodule // result_fifo

`default_nettype wire

// >>> verilog/sar_readout_ctrl.v
`include "sar_readout_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module sar_readout_ctrl
(
  input wire clock,
  input wire sys_rst,
  input wire convert_start_n,
  input wire chipSelect_n,
  input wire readStrobe_n,
  input wire byteSelect,
  input wire powerdown_reset_n,
  input wire [11:0] analogWord,
  output reg busy,
  output reg [11:0] parallel_data_pins_out,
  output reg parallel_data_pins_oe_n,
  output reg resultInvalid,
  output reg poweredDown,
  output wire bufferFull
);

  localparam [2:0] IDLE = `ST_IDLE;
  localparam [2:0] CONVERT = `ST_CONVERT;
  localparam [2:0] PUSH = `ST_PUSH;
  localparam [2:0] RESET = `ST_RESET;
  localparam [2:0] POWERDOWN = `ST_POWERDOWN;
  localparam [2:0] WAKE = `ST_WAKE;
  localparam [15:0] CONV_COUNT = `CONV_CYCLES;
  localparam [15:0] PD_ENTRY_COUNT = `PD_ENTRY_CYCLES;
  localparam [15:0] PD_EXIT_COUNT = `PD_EXIT_CYCLES;

  // byte-mode view of a result word
  function [11:0] byteView;
    input [11:0] word;
    input highHalf;
    begin
      if (highHalf)
        byteView = {word[`LOW_NIBBLE_MSB:0], `BYTE_ZERO_FILL};
      else
        byteView = word;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only the second
  reg [1:0] convSync;
  reg [1:0] csSync;
  reg [1:0] rdSync;
  reg [1:0] byteSync;
  reg [1:0] pwdSync;
  reg [11:0] wordSync1;
  reg [11:0] wordSync2;
  reg convPrev;
  reg csPrev;

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      convSync <= 2'h3;
      csSync <= 2'h3;
      rdSync <= 2'h3;
      byteSync <= 2'h0;
      pwdSync <= 2'h3;
      wordSync1 <= 12'h000;
      wordSync2 <= 12'h000;
      convPrev <= 1'b1;
      csPrev <= 1'b1;
    end
    else
    begin
      convSync <= {convSync[0], convert_start_n};
      csSync <= {csSync[0], chipSelect_n};
      rdSync <= {rdSync[0], readStrobe_n};
      byteSync <= {byteSync[0], byteSelect};
      pwdSync <= {pwdSync[0], powerdown_reset_n};
      wordSync1 <= analogWord;
      wordSync2 <= wordSync1;
      convPrev <= convSync[1];
      csPrev <= csSync[1];
    end
  end

  wire convN = convSync[1];
  wire csN = csSync[1];
  wire rdN = rdSync[1];
  wire byteHigh = byteSync[1];
  wire pwdN = pwdSync[1];
  wire convFall = convPrev & ~convN;
  wire csFall = csPrev & ~csN;
  // either falling edge opens a conversion when the other line is low
  wire startEvent = (convFall & ~csN) | (csFall & ~convN);
  // select falling mid-conversion with start high kills it
  wire abortEvent = csFall & convN & busy;
  wire readActive = ~csN & ~rdN;

  ////////////////////////////////////////////////////////////////////////////
  // control state machine
  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] timer;
  reg [11:0] captured;
  reg markReset;
  reg [2:0] initCount;
  wire fifoInReady;
  wire fifoOutValid;
  wire [11:0] fifoOutData;
  wire fifoPush = (state == PUSH);
  wire flushFifo = (state == RESET) | (state == POWERDOWN);

  // next-state choice; reset pin outranks every other event
  always @*
  begin
    next_state = state;
    case (state)
      IDLE:
      begin
        if (!pwdN)
          next_state = RESET;
        else if (startEvent)
          next_state = CONVERT;
      end
      CONVERT:
      begin
        if (!pwdN)
          next_state = RESET;
        else if (abortEvent)
          next_state = IDLE;
        else if (timer == CONV_COUNT - `CONV_SLACK_CYCLES)
          next_state = PUSH;
      end
      PUSH:
      begin
        if (!pwdN)
          next_state = RESET;
        else if (fifoInReady)
          next_state = IDLE;
      end
      RESET:
      begin
        if (pwdN)
          next_state = IDLE;
        else if (timer >= PD_ENTRY_COUNT)
          next_state = POWERDOWN;
      end
      POWERDOWN:
      begin
        if (pwdN)
          next_state = WAKE;
      end
      WAKE:
      begin
        if (!pwdN)
          next_state = RESET;
        else if (timer >= PD_EXIT_COUNT - `PD_EXIT_SLACK_CYCLES)
          next_state = IDLE;
      end
      default:
        next_state = IDLE;
    endcase
  end

  // state, timer and capture register
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      state <= RESET;
      timer <= 16'h0000;
      captured <= `RESULT_RESET_VALUE;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        timer <= 16'h0000;
      else if (timer != 16'hFFFF)
        timer <= timer + 16'h0001;
      // analog word taken at end of conversion, straight binary as given
      if (state == CONVERT && next_state == PUSH)
        captured <= wordSync2;
    end
  end

  // busy spans the conversion and the wait for buffer room
  always @(posedge clock)
  begin
    if (sys_rst)
      busy <= 1'b0;
    else
      busy <= (next_state == CONVERT) | (next_state == PUSH);
  end

  ////////////////////////////////////////////////////////////////////////////
  // initialisation count: the first results after reset are flagged
  always @(posedge clock)
  begin
    if (sys_rst || state == RESET || state == POWERDOWN)
      initCount <= 3'h0;
    else if (fifoPush && fifoInReady && initCount != `INIT_CONVERSIONS)
      initCount <= initCount + 3'h1;
  end

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      resultInvalid <= 1'b1;
      poweredDown <= 1'b0;
    end
    else
    begin
      resultInvalid <= (initCount != `INIT_CONVERSIONS);
      poweredDown <= (state == POWERDOWN) | (state == WAKE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold the word still while a read is on the bus so halves match
  wire fifoDrain = ~readActive & ~markReset;

  // result buffer; a stalled drain holds the converter in busy
  result_fifo
  #(
    .WIDTH(`RESULT_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .PTR_WIDTH(`FIFO_PTR_WIDTH)
  )
  resultBuffer
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .flush(flushFifo),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(captured),
    .outValid(fifoOutValid),
    .outReady(fifoDrain),
    .outData(fifoOutData)
  );

  assign bufferFull = ~fifoInReady;

  ////////////////////////////////////////////////////////////////////////////
  // output word: reset marker during reset or after an abort, else results
  reg [11:0] outWord;

  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      outWord <= `RESET_MARK_CODE;
      markReset <= 1'b1;
    end
    else if (state == RESET || next_state == RESET)
    begin
      outWord <= `RESET_MARK_CODE;
      markReset <= 1'b1;
    end
    else if (state == CONVERT && abortEvent)
    begin
      outWord <= `RESET_MARK_CODE;
      markReset <= 1'b0;
    end
    else
    begin
      markReset <= 1'b0;
      if (fifoOutValid && fifoDrain)
        outWord <= fifoOutData;
    end
  end

  // pins follow the live byte select, so toggled or held strobe both work
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      parallel_data_pins_out <= 12'h000;
      parallel_data_pins_oe_n <= 1'b1;
    end
    else
    begin
      parallel_data_pins_out <= byteView(outWord, byteHigh);
      parallel_data_pins_oe_n <= ~readActive;
    end
  end

endmodule // sar_readout_ctrl

`default_nettype wire
